//--- rtl/memmap_pkg.sv
// Constants for the unified memory map decoder.
// Assumes a 24-bit byte address from the CPU core.
package memmap_pkg;
   localparam int ADDR_W = 24;
   localparam int CLK_HZ = 10000000;
   localparam int CLK_PERIOD_PS = 100000;
   // Timing: extension RAM access and peripheral-bus access
   localparam int EXTENSION_RAM_ACCESS_PS = 31250;
   localparam int PBUS_ACCESS_PS = 62500;
   localparam int EXTENSION_RAM_CYCLES = (EXTENSION_RAM_ACCESS_PS / CLK_PERIOD_PS) < 1 ? 1 : (EXTENSION_RAM_ACCESS_PS / CLK_PERIOD_PS);
   localparam int PBUS_WAIT_STATES = 2;
   // Enable bit positions
   localparam int GLOBAL_EN_BIT = 2;
   localparam int SMALL_RAM_EN_BIT = 2;
   localparam int LARGE_RAM_EN_BIT = 3;
   localparam int FIRST_CAN_CONTROLLER_EN_BIT = 0;
   localparam int SECOND_CAN_CONTROLLER_EN_BIT = 1;
   localparam int RTC_EN_BIT = 4;
   localparam int PWM_EN_BIT = 6;
   localparam int ASYNC_EN_BIT = 7;
   localparam int SYNC_EN_BIT = 8;
   localparam int I2C_EN_BIT = 9;
   localparam int MISC_EN_BIT = 10;
   localparam logic [15:0] PERIPH_SEL_RESET = 16'h0000;
   localparam logic [15:0] SYS_CONFIG_RESET = 16'h0000;
   // Flash ranges
   localparam logic [23:0] FL_LOW_BASE = 24'h000000;
   localparam logic [23:0] FL_LOW_LAST = 24'h007FFF;
   localparam logic [23:0] FL_B4_BASE = 24'h018000;
   localparam logic [23:0] FL_B1_BASE = 24'h070000;
   localparam logic [23:0] FL_LAST = 24'h08FFFF;
   localparam logic [23:0] TEST_FL_LAST = 24'h001FFF;
   localparam logic [23:0] FL_CTRL_BASE = 24'h0E0000;
   localparam logic [23:0] FL_CTRL_LAST = 24'h0EFFFF;
   // Internal RAM and register areas
   localparam logic [23:0] DUAL_PORT_INTERNAL_RAM_BASE = 24'h00F600;
   localparam logic [23:0] DUAL_PORT_INTERNAL_RAM_LAST = 24'h00FDFF;
   localparam logic [23:0] SFR_BASE = 24'h00FE00;
   localparam logic [23:0] SFR_LAST = 24'h00FFFF;
   localparam logic [23:0] ESFR_BASE = 24'h00F000;
   localparam logic [23:0] ESFR_LAST = 24'h00F1FF;
   // Extension RAM
   localparam logic [23:0] SRAM_BASE = 24'h00E000;
   localparam logic [23:0] SRAM_LAST = 24'h00E7FF;
   localparam logic [23:0] LRAM_BASE = 24'h0F0000;
   localparam logic [23:0] LRAM_LAST = 24'h0F7FFF;
   // Peripheral windows, 256 bytes each, keyed by address bits 23:8
   localparam logic [15:0] WIN_PAGE_HI = 16'h00E0;
   localparam int NUM_WIN = 8;
   localparam logic [3:0] WIN_LOW [NUM_WIN] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'h9, 4'h8, 4'hA, 4'hB};
   localparam int WIN_EN_BIT [NUM_WIN] = '{0, 1, 4, 6, 7, 8, 9, 10};
   localparam int EXT_SEG_LINES_CAN = 4;
   localparam int EXT_SEG_LINES_FULL = 8;
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'b00001,
      ST_WAIT = 5'b00010,
      ST_DONE = 5'b00100,
      ST_EXT = 5'b01000,
      ST_ERR = 5'b10000
   } acc_state_t;
endpackage

//--- rtl/unified_memory_map_decoder.sv
// Unified 16 Mbyte address decoder for the on-chip memories and peripheral bus.
// Assumes a single-request CPU: a new request only after ack_o, err_o or sel_ext_o.
// Overview of operation
// [RQ1] One linear 16M space, byte and word accesses
// [RQ2] No read of bank under modification
// [RQ3] Bootstrap shows test block at zero
// [RQ4] User flash blocks at documented addresses
// [RQ5] Extension RAM: one cycle, byte or word
// [RQ6] Small RAM only with both enables
// [RQ7] Large RAM gated, else external bus
// [RQ8] Requester avoids stack, banks, bits there
// [RQ9] First CAN window needs both enables
// [RQ10] Second CAN window needs both enables
// [RQ11] CAN use limits segment lines to four
// [RQ12] Real-time clock window needs both enables
// [RQ13] PWM window gated, word only
// [RQ14] Async serial window needs both enables
// [RQ15] Sync serial window needs both enables
// [RQ16] I2C window needs both enables
// [RQ17] Miscellaneous window needs both enables
// [RQ18] Peripheral windows: word only, two waits
// [RQ19] Disabled peripheral stays fully invisible
// [RQ20] Flash 32-bit fetch, 16-bit data
// [RQ21] Two 512-byte register areas reserved
// [RQ22] Internal RAM holds register banks
// [RQ23] Unclaimed addresses go to external bus
`timescale 1ns/100ps
module unified_memory_map_decoder
#(
   parameter int WAIT_STATES = memmap_pkg::PBUS_WAIT_STATES
)
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic req_i,
   input wire logic [memmap_pkg::ADDR_W-1:0] addr_i,
   input wire logic write_i,
   input wire logic byte_i,
   input wire logic fetch_i,
   input wire logic bootstrap_i,
   input wire logic [15:0] system_config_reg_i,
   input wire logic [15:0] periph_bus_select_reg_i,
   input wire logic bank0_busy_i,
   input wire logic bank1_busy_i,
   output logic ack_o,
   output logic err_o,
   output logic sel_flash_o,
   output logic sel_test_flash_o,
   output logic flash_bank1_o,
   output logic flash_wide_o,
   output logic sel_flash_ctrl_o,
   output logic sel_dual_port_internal_ram_o,
   output logic sel_sfr_o,
   output logic sel_esfr_o,
   output logic sel_small_ext_ram_o,
   output logic sel_large_ext_ram_o,
   output logic [memmap_pkg::NUM_WIN-1:0] sel_win_o,
   output logic sel_ext_o,
   output logic [3:0] ext_seg_lines_o,
   output logic [memmap_pkg::NUM_WIN-1:0] win_visible_o
);
   import memmap_pkg::*;

   // Wait counter is four bits and counts down from WAIT_STATES - 1
   if (WAIT_STATES < 1 || WAIT_STATES > 15)
   begin : g_bad_wait
      $error("WAIT_STATES out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   wire global_en = system_config_reg_i[GLOBAL_EN_BIT];
   wire in_low_fl = addr_i <= FL_LOW_LAST;
   wire in_high_fl = addr_i >= FL_B4_BASE && addr_i <= FL_LAST;
   wire hit_test = bootstrap_i && addr_i <= TEST_FL_LAST;                 // see [RQ3]
   wire hit_flash = !hit_test && (in_low_fl || in_high_fl);               // see [RQ4]
   wire bank1 = addr_i >= FL_B1_BASE;
   // Test block lives in bank 0, so its reads also honour bank 0 busy
   wire bank_busy = bank1 ? bank1_busy_i : bank0_busy_i;
   wire fl_conflict = (hit_flash || hit_test) && !write_i &&
                      (hit_test ? bank0_busy_i : bank_busy);            // see [RQ2]
   wire hit_fctrl = addr_i >= FL_CTRL_BASE && addr_i <= FL_CTRL_LAST;
   wire hit_dual_port_internal_ram = addr_i >= DUAL_PORT_INTERNAL_RAM_BASE && addr_i <= DUAL_PORT_INTERNAL_RAM_LAST;            // see [RQ22]
   wire hit_sfr = addr_i >= SFR_BASE && addr_i <= SFR_LAST;               // see [RQ21]
   wire hit_esfr = addr_i >= ESFR_BASE && addr_i <= ESFR_LAST;            // see [RQ21]
   wire hit_sram = global_en && periph_bus_select_reg_i[SMALL_RAM_EN_BIT] &&
                   addr_i >= SRAM_BASE && addr_i <= SRAM_LAST;            // see [RQ6]
   wire hit_lram = global_en && periph_bus_select_reg_i[LARGE_RAM_EN_BIT] &&
                   addr_i >= LRAM_BASE && addr_i <= LRAM_LAST;            // see [RQ7]
   wire [NUM_WIN-1:0] win_hit;
   wire [NUM_WIN-1:0] win_vis;

   genvar g;
   generate
      for (g = 0; g < NUM_WIN; g++)
      begin : g_win
         // Individual enable alone claims nothing without the global enable
         assign win_vis[g] = global_en && periph_bus_select_reg_i[WIN_EN_BIT[g]]; // see [RQ19]
         assign win_hit[g] = win_vis[g] && addr_i[23:12] == WIN_PAGE_HI[15:4] &&
                             addr_i[11:8] == WIN_LOW[g];         // see [RQ9] [RQ10] [RQ12] [RQ13]
      end
   endgenerate
   // Windows 0..7: FIRST_CAN_CONTROLLER, SECOND_CAN_CONTROLLER, RTC, PWM, async, sync, I2C, misc; see [RQ14] [RQ15] [RQ16] [RQ17]

   wire hit_pbus = |win_hit;
   wire pbus_bad_size = hit_pbus && byte_i;                               // see [RQ13] [RQ18]
   wire hit_onchip = hit_flash || hit_test || hit_fctrl || hit_dual_port_internal_ram || hit_sfr ||
                     hit_esfr || hit_sram || hit_lram || hit_pbus;
   wire hit_ext = !hit_onchip;                                            // see [RQ23]
   wire can_used = win_vis[0] || win_vis[1];
   wire [3:0] seg_next = can_used ? 4'(EXT_SEG_LINES_CAN) : 4'(EXT_SEG_LINES_FULL); // see [RQ11]
   // Whole space taken, any size; only the peripheral bus refuses bytes
   wire refuse = fl_conflict || pbus_bad_size;                            // see [RQ1]

   ////////////////////////////////////////////////////////////////////////////
   // Access sequencer
   acc_state_t state_reg;
   acc_state_t state_next;
   logic [3:0] wait_reg;
   logic [3:0] wait_next;

   always_comb
   begin
      state_next = state_reg;
      wait_next = wait_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (req_i)
            begin
               if (refuse)
                  state_next = ST_ERR;
               else if (hit_pbus)
               begin
                  state_next = ST_WAIT;                                   // see [RQ18]
                  wait_next = 4'(WAIT_STATES - 1);
               end
               else if (hit_ext)
                  state_next = ST_EXT;
               else
                  state_next = ST_DONE;                                   // see [RQ5]
            end
         end
         ST_WAIT:
         begin
            if (wait_reg == 4'h0)
               state_next = ST_DONE;
            else
               wait_next = wait_reg - 4'h1;
         end
         ST_DONE: state_next = ST_IDLE;
         ST_EXT: state_next = ST_IDLE;
         ST_ERR: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   wire take = state_reg == ST_IDLE && req_i;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_reg <= ST_IDLE;
         wait_reg <= 4'h0;
      end
      else
      begin
         state_reg <= state_next;
         wait_reg <= wait_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered selects, held from request to answer
   wire sel_drop = state_next == ST_IDLE;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_flash_o <= 1'b0;
      else if (take)
         sel_flash_o <= hit_flash && !refuse;
      else if (sel_drop)
         sel_flash_o <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_test_flash_o <= 1'b0;
      else if (take)
         sel_test_flash_o <= hit_test && !refuse;
      else if (sel_drop)
         sel_test_flash_o <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         flash_bank1_o <= 1'b0;
      else if (take)
         flash_bank1_o <= hit_flash && bank1;
      else if (sel_drop)
         flash_bank1_o <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         flash_wide_o <= 1'b0;
      else if (take)
         flash_wide_o <= (hit_flash || hit_test) && fetch_i && !write_i; // see [RQ20]
      else if (sel_drop)
         flash_wide_o <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_flash_ctrl_o <= 1'b0;
      else if (take)
         sel_flash_ctrl_o <= hit_fctrl;
      else if (sel_drop)
         sel_flash_ctrl_o <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_dual_port_internal_ram_o <= 1'b0;
      else if (take)
         sel_dual_port_internal_ram_o <= hit_dual_port_internal_ram;
      else if (sel_drop)
         sel_dual_port_internal_ram_o <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_sfr_o <= 1'b0;
      else if (take)
         sel_sfr_o <= hit_sfr;
      else if (sel_drop)
         sel_sfr_o <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_esfr_o <= 1'b0;
      else if (take)
         sel_esfr_o <= hit_esfr;
      else if (sel_drop)
         sel_esfr_o <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_small_ext_ram_o <= 1'b0;
      else if (take)
         sel_small_ext_ram_o <= hit_sram;
      else if (sel_drop)
         sel_small_ext_ram_o <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_large_ext_ram_o <= 1'b0;
      else if (take)
         sel_large_ext_ram_o <= hit_lram;
      else if (sel_drop)
         sel_large_ext_ram_o <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_win_o <= '0;
      else if (take)
         sel_win_o <= refuse ? '0 : win_hit;
      else if (sel_drop)
         sel_win_o <= '0;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_ext_o <= 1'b0;
      else if (take)
         sel_ext_o <= hit_ext;                                            // see [RQ6] [RQ7] [RQ23]
      else if (sel_drop)
         sel_ext_o <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answers and status
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         ext_seg_lines_o <= 4'h0;
         win_visible_o <= '0;
      end
      else
      begin
         // External answers come from the bus interface itself
         ack_o <= state_next == ST_DONE;
         err_o <= state_next == ST_ERR;
         ext_seg_lines_o <= seg_next;
         win_visible_o <= win_vis;
      end
   end
endmodule

//--- sim/unified_memory_map_decoder_chk.sv
// Checker: answer timing, select gating and window visibility.
// Assumes binding to the decoder with default wait states.
`timescale 1ns/100ps
module unified_memory_map_decoder_chk
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [memmap_pkg::ADDR_W-1:0] addr_i,
   input wire logic byte_i,
   input wire logic bootstrap_i,
   input wire logic bank0_busy_i,
   input wire logic [15:0] system_config_reg_i,
   input wire logic [15:0] periph_bus_select_reg_i,
   input wire logic ack_o,
   input wire logic err_o,
   input wire logic sel_test_flash_o,
   input wire logic sel_small_ext_ram_o,
   input wire logic sel_large_ext_ram_o,
   input wire logic [memmap_pkg::NUM_WIN-1:0] sel_win_o,
   input wire logic sel_ext_o,
   input wire logic [3:0] ext_seg_lines_o,
   input wire logic [memmap_pkg::NUM_WIN-1:0] win_visible_o
);
   import memmap_pkg::*;
   wire logic [15:0] pb = periph_bus_select_reg_i;
   wire logic gl = system_config_reg_i[2];
   wire logic [7:0] vis_exp = {8{gl}} & {pb[10], pb[9], pb[8], pb[7], pb[6], pb[4], pb[1], pb[0]};
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   ////////////////////////////////////////////////////////////////////////////////
   AST_WIN_VISIBLE: assert property ($past(nrst_i) |-> win_visible_o == $past(vis_exp))
      else $error("window visibility wrong");
   AST_SEG_LINES: assert property ($past(nrst_i) |-> ext_seg_lines_o == ($past(|vis_exp[1:0]) ? 4'h4 : 4'h8))
      else $error("segment line count wrong");
   AST_WIN_WAIT: assert property ($rose(|sel_win_o) |-> !ack_o ##1 !ack_o ##1 ack_o)
      else $error("window wait states wrong");
   AST_WIN_GATE: assert property ($rose(|sel_win_o) |-> (sel_win_o & ~$past(vis_exp)) == 8'h00)
      else $error("disabled window selected");
   AST_WIN_WORD: assert property ($rose(|sel_win_o) |-> !$past(byte_i))
      else $error("byte access reached window");
   AST_SMALL_RAM: assert property ($rose(sel_small_ext_ram_o) |-> ack_o && $past(gl && pb[2] && addr_i[23:11] == 13'h001C))
      else $error("small RAM select wrong");
   AST_LARGE_RAM: assert property ($rose(sel_large_ext_ram_o) |-> ack_o && $past(gl && pb[3] && addr_i[23:15] == 9'h01E))
      else $error("large RAM select wrong");
   AST_TEST_FLASH: assert property ($rose(sel_test_flash_o) |-> $past(bootstrap_i && !bank0_busy_i && addr_i < 24'h002000))
      else $error("test block select wrong");
   AST_ERR_QUIET: assert property (err_o |-> (!sel_ext_o && sel_win_o == 8'h00) ##1 !err_o)
      else $error("refusal not clean");
endmodule
bind unified_memory_map_decoder unified_memory_map_decoder_chk u_chk
(
   .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .byte_i(byte_i), .bootstrap_i(bootstrap_i),
   .bank0_busy_i(bank0_busy_i), .system_config_reg_i(system_config_reg_i),
   .periph_bus_select_reg_i(periph_bus_select_reg_i), .ack_o(ack_o), .err_o(err_o),
   .sel_test_flash_o(sel_test_flash_o), .sel_small_ext_ram_o(sel_small_ext_ram_o),
   .sel_large_ext_ram_o(sel_large_ext_ram_o), .sel_win_o(sel_win_o), .sel_ext_o(sel_ext_o),
   .ext_seg_lines_o(ext_seg_lines_o), .win_visible_o(win_visible_o)
);

//--- sim/cpu_model.sv
// Requester model: one access at a time, request pulsed for one take.
// Assumes an answer by ack, refusal or external select.
`timescale 1ns/100ps
module cpu_model
(
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic err_i,
   input wire logic ext_i,
   output logic req_o,
   output logic [memmap_pkg::ADDR_W-1:0] addr_o,
   output logic write_o,
   output logic byte_o,
   output logic fetch_o
);
   import memmap_pkg::*;
   initial
   begin
      req_o = 1'b0;
      addr_o = 24'h000000;
      {write_o, byte_o, fetch_o} = 3'h0;
   end
   // Plain loads and stores only, never bit operations
   task automatic access(input logic [23:0] a, input logic w, b, f, output int code, output int n);
      @(posedge clk_i);
      #1;
      {addr_o, write_o, byte_o, fetch_o, req_o} = {a, w, b, f, 1'b1};
      @(posedge clk_i);
      #1;
      // Held longer, a level request would be taken twice
      req_o = 1'b0;
      // Answers launch on the take edge, so look before the next one
      n = 1;
      while (!(ack_i | err_i | ext_i) && n < 9)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      code = ack_i ? 0 : err_i ? 1 : ext_i ? 2 : 3;
   endtask
endmodule

//--- sim/unified_memory_map_decoder_tb_top.sv
// Testbench: drives the decoder through the requester model.
// Assumes default wait states and a 100 ns clock.
`timescale 1ns/100ps
module unified_memory_map_decoder_tb_top;
   import memmap_pkg::*;
   localparam logic [18:0] FL = 19'h00400, TF = 19'h00200, B1 = 19'h00100, WD = 19'h00080, CT = 19'h00040;
   localparam logic [18:0] IR = 19'h00020, SF = 19'h00010, ES = 19'h00008, SM = 19'h00004, LG = 19'h00002;
   localparam logic [18:0] EX = 19'h00001, NO = 19'h00000;
   logic clk_i, nrst_i, bootstrap_i, bank0_busy_i, bank1_busy_i;
   logic [15:0] sc, pb;
   wire logic req_i, write_i, byte_i, fetch_i, ack_o, err_o;
   wire logic [23:0] addr_i;
   wire logic [18:0] sel;
   wire logic [3:0] seg;
   wire logic [7:0] vis;
   int fail_count = 0;
   int total_checks = 0;
   unified_memory_map_decoder u_unified_memory_map_decoder
   (
      .clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i), .addr_i(addr_i), .write_i(write_i), .byte_i(byte_i),
      .fetch_i(fetch_i), .bootstrap_i(bootstrap_i), .system_config_reg_i(sc), .periph_bus_select_reg_i(pb),
      .bank0_busy_i(bank0_busy_i), .bank1_busy_i(bank1_busy_i), .ack_o(ack_o), .err_o(err_o),
      .sel_flash_o(sel[10]), .sel_test_flash_o(sel[9]), .flash_bank1_o(sel[8]), .flash_wide_o(sel[7]),
      .sel_flash_ctrl_o(sel[6]), .sel_dual_port_internal_ram_o(sel[5]), .sel_sfr_o(sel[4]), .sel_esfr_o(sel[3]),
      .sel_small_ext_ram_o(sel[2]), .sel_large_ext_ram_o(sel[1]), .sel_win_o(sel[18:11]),
      .sel_ext_o(sel[0]), .ext_seg_lines_o(seg), .win_visible_o(vis)
   );
   cpu_model u_cpu_model
   (
      .clk_i(clk_i), .ack_i(ack_o), .err_i(err_o), .ext_i(sel[0]), .req_o(req_i), .addr_o(addr_i),
      .write_o(write_i), .byte_o(byte_i), .fetch_o(fetch_i)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic acc(input logic [23:0] a, input logic w, b, f, input int code, input logic [18:0] s);
      int c, n;
      u_cpu_model.access(a, w, b, f, c, n);
      check("answer", c, code);
      check("cycles", n, (code == 0 && s[18:11] != 8'h00) ? 1 + PBUS_WAIT_STATES : 1);
      check("selects", sel, s);
   endtask
   task automatic t_flash;
      acc(24'h000000, 0, 0, 0, 0, FL);
      acc(24'h007FFF, 0, 1, 0, 0, FL);
      acc(24'h008000, 0, 0, 0, 2, EX);
      acc(24'h018000, 0, 0, 1, 0, FL | WD);
      acc(24'h06FFFE, 0, 0, 0, 0, FL);
      acc(24'h070000, 0, 0, 0, 0, FL | B1);
      acc(24'h090000, 1, 0, 0, 2, EX);
      acc(24'h0E0000, 1, 0, 0, 0, CT);
      acc(24'h00F600, 1, 1, 0, 0, IR);
      acc(24'h00FFFF, 0, 1, 0, 0, SF);
      acc(24'h00F1FE, 0, 0, 0, 0, ES);
      acc(24'hFFFFFF, 1, 1, 0, 2, EX);
   endtask
   task automatic t_boot;
      bootstrap_i = 1'b1;
      acc(24'h001FFE, 0, 0, 1, 0, TF | WD);
      acc(24'h002000, 0, 0, 0, 0, FL);
      bank0_busy_i = 1'b1;
      acc(24'h000000, 0, 0, 0, 1, NO);
      // A refused fetch still flags the path and bank it aimed at
      acc(24'h018000, 0, 0, 1, 1, WD);
      acc(24'h080000, 0, 0, 0, 0, FL | B1);
      acc(24'h018000, 1, 0, 0, 0, FL);
      {bank0_busy_i, bank1_busy_i} = 2'h1;
      acc(24'h070000, 0, 0, 1, 1, B1 | WD);
      acc(24'h060000, 0, 0, 1, 0, FL | WD);
      {bank1_busy_i, bootstrap_i} = 2'h0;
   endtask
   task automatic t_extension_ram;
      {sc, pb} = {16'h0004, 16'h0004};
      acc(24'h00E7FF, 1, 1, 0, 0, SM);
      acc(24'h0F0000, 0, 1, 0, 2, EX);
      pb = 16'h0008;
      acc(24'h0F7FFE, 1, 0, 0, 0, LG);
      acc(24'h00E000, 0, 0, 0, 2, EX);
      sc = 16'h0000;
      acc(24'h0F0000, 0, 0, 0, 2, EX);
   endtask
   task automatic t_windows;
      for (int i = 0; i < NUM_WIN; i++)
      begin
         {sc, pb} = {16'h0004, 16'h0000};
         pb[WIN_EN_BIT[i]] = 1'b1;
         acc({12'h00E, WIN_LOW[i], 8'hFE}, i[0], 0, 0, 0, 19'h00800 << i);
         check("seg", seg, i < 2 ? 4'h4 : 4'h8);
         check("vis", vis, 8'h01 << i);
         acc({12'h00E, WIN_LOW[i], 8'h00}, 0, 1, 0, 1, NO);
         acc({12'h00E, WIN_LOW[(i + 1) % NUM_WIN], 8'h00}, 0, 0, 0, 2, EX);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial
   begin
      {nrst_i, bootstrap_i, bank0_busy_i, bank1_busy_i, sc, pb} = 36'h0;
      repeat (20) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      t_flash;
      t_boot;
      t_extension_ram;
      t_windows;
      complete_run;
   end
   // Whole run is under two hundred cycles
   initial
   begin
      #2000000;
      fail_count++;
      complete_run;
   end
endmodule
